// ### hw/sbsp_port.sv
// sbsp_port: control, burst counter and storage of a flow-through burst sram
// assumes: all pin inputs synchronous to CLK except the output enable and sleep
// Function
// - synchronous inputs sampled on rising clock edge
// - deselect decodes power down, outputs tristated
// - sleep forces snooze, outputs tristated asynchronously
// - processor strobe starts read; output enable gates
// - controller strobe starts write or read burst
// - continue with advance steps burst address
// - advance high holds address, repeats access
// - write decode from global or gated bytes
// - byte lane write gates byte and parity
// - processor strobe edge reads, write follows
// - outputs tristated until a read accepted
// - mode high gives interleaved burst order
// - mode defaults interleaved, low selects linear
`default_nettype none
module sbsp_port
  import sbsp_pkg::*;
#(
  parameter int ADDR_W = SBSP_ADDR_W,
  parameter int LANES  = SBSP_LANES
) (
  input  wire logic                           CLK,
  input  wire logic                           RESET,
  input  wire logic [ADDR_W-SBSP_BURST_W-1:0] ADDRESS_HI,
  input  wire logic [SBSP_BURST_W-1:0]        BURST_LSB_ADDRESS,
  input  wire logic                           CHIP_SELECT_N,
  input  wire logic                           CHIP_SELECT_HI,
  input  wire logic                           CHIP_SELECT2_N,
  input  wire logic                           PROCESSOR_ADDR_STROBE_N,
  input  wire logic                           CONTROLLER_ADDR_STROBE_N,
  input  wire logic                           BURST_ADVANCE_N,
  input  wire logic                           ALL_BYTES_WRITE_N,
  input  wire logic                           BYTE_WRITE_GATE_N,
  input  wire logic [LANES-1:0]               BYTE_LANE_WRITE_N,
  input  wire logic                           OUTPUT_ENABLE_N,
  input  wire logic                           SLEEP_REQUEST,
  input  wire logic                           BURST_ORDER_SEL,
  input  wire logic [LANES*SBSP_BYTE_W-1:0]   DATA_LANE_IN,
  output logic      [LANES*SBSP_BYTE_W-1:0]   DATA_LANE_OUT,
  output logic                                DATA_LANE_OE,
  input  wire logic [LANES-1:0]               PARITY_LANE_IN,
  output logic      [LANES-1:0]               PARITY_LANE_OUT,
  output logic                                PARITY_LANE_OE,
  output logic                                POWER_DOWN
);
  localparam int DEPTH = 1 << ADDR_W;

  sbsp_op_t                    op;
  sbsp_burst_t                 burst_reg;
  sbsp_burst_t                 burst_next;
  logic [ADDR_W-SBSP_BURST_W-1:0] addr_hi_reg;
  logic [ADDR_W-SBSP_BURST_W-1:0] addr_hi_next;
  logic [SBSP_BURST_W-1:0]     low_addr;
  logic [ADDR_W-1:0]           access_addr;
  logic                        active_reg;
  logic                        drive_reg;
  logic                        pd_reg;
  logic                        sel_full;
  logic                        deselect;
  logic                        wr_any;
  logic                        do_write;
  logic                        do_read;
  logic [LANES-1:0]            lane_we;

  // ------------------------------------------------------------
  // cycle decode
  // ------------------------------------------------------------
  assign sel_full = !CHIP_SELECT_N && CHIP_SELECT_HI && !CHIP_SELECT2_N;
  assign deselect = (CHIP_SELECT_N && !CONTROLLER_ADDR_STROBE_N) ||
                    ((!PROCESSOR_ADDR_STROBE_N || !CONTROLLER_ADDR_STROBE_N) &&
                     !CHIP_SELECT_N && (!CHIP_SELECT_HI || CHIP_SELECT2_N));
  assign wr_any = !ALL_BYTES_WRITE_N || (!BYTE_WRITE_GATE_N && !(&BYTE_LANE_WRITE_N));

  always_comb begin
    op = SBSP_OP_IDLE;
    if (SLEEP_REQUEST) begin
      op = SBSP_OP_SNOOZE;
    end else if (deselect) begin
      op = SBSP_OP_DESELECT;
    end else if (sel_full && !PROCESSOR_ADDR_STROBE_N) begin
      op = SBSP_OP_START_READ;
    end else if (sel_full && !CONTROLLER_ADDR_STROBE_N) begin
      op = SBSP_OP_START_CTL;
    end else if (active_reg && CONTROLLER_ADDR_STROBE_N && (PROCESSOR_ADDR_STROBE_N || CHIP_SELECT_N)) begin
      op = BURST_ADVANCE_N ? SBSP_OP_HOLD : SBSP_OP_STEP;
    end
  end

  // ------------------------------------------------------------
  // burst address
  // ------------------------------------------------------------
  always_comb begin
    burst_next   = burst_reg;
    addr_hi_next = addr_hi_reg;
    case (op)
      SBSP_OP_START_READ, SBSP_OP_START_CTL: begin
        burst_next.start = BURST_LSB_ADDRESS;
        burst_next.count = SBSP_COUNT_ZERO;
        addr_hi_next     = ADDRESS_HI;
      end
      SBSP_OP_STEP: begin
        burst_next.count = burst_reg.count + SBSP_COUNT_STEP;
      end
      default: begin
        burst_next = burst_reg;
      end
    endcase
  end

  // mode pin high (pulled up off chip) interleaves, low is linear
  assign low_addr = BURST_ORDER_SEL ? (burst_next.start ^ burst_next.count)
                                    : (burst_next.start + burst_next.count);
  assign access_addr = {addr_hi_next, low_addr};

  assign do_write = ((op == SBSP_OP_START_CTL) || (op == SBSP_OP_STEP) || (op == SBSP_OP_HOLD)) && wr_any;
  assign do_read  = (op == SBSP_OP_START_READ) ||
                    (((op == SBSP_OP_START_CTL) || (op == SBSP_OP_STEP) || (op == SBSP_OP_HOLD)) && !wr_any);

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      burst_reg   <= '0;
      addr_hi_reg <= '0;
    end else begin
      burst_reg   <= burst_next;
      addr_hi_reg <= addr_hi_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      active_reg <= 1'b0;
    end else if ((op == SBSP_OP_START_READ) || (op == SBSP_OP_START_CTL)) begin
      active_reg <= 1'b1;
    end else if (op == SBSP_OP_DESELECT) begin
      active_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= do_read;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pd_reg <= 1'b1;
    end else if (op == SBSP_OP_DESELECT) begin
      pd_reg <= 1'b1;
    end else if (op != SBSP_OP_SNOOZE && op != SBSP_OP_IDLE) begin
      pd_reg <= 1'b0;
    end
  end

  // asynchronous gating by output enable and sleep
  assign DATA_LANE_OE   = drive_reg && !OUTPUT_ENABLE_N && !SLEEP_REQUEST;
  assign PARITY_LANE_OE = DATA_LANE_OE;
  assign POWER_DOWN     = pd_reg || SLEEP_REQUEST;

  // ------------------------------------------------------------
  // per lane storage
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [SBSP_WORD_W-1:0] mem_lane [DEPTH];
      logic [SBSP_WORD_W-1:0] rd_reg;
      assign lane_we[g] = do_write && (!ALL_BYTES_WRITE_N || !BYTE_LANE_WRITE_N[g]);
      always_ff @(posedge CLK) begin
        if (!RESET && lane_we[g]) begin
          mem_lane[access_addr] <= {PARITY_LANE_IN[g], DATA_LANE_IN[g*SBSP_BYTE_W +: SBSP_BYTE_W]};
        end
      end
      always_ff @(posedge CLK) begin
        if (RESET) begin
          rd_reg <= '0;
        end else if (do_read) begin
          rd_reg <= mem_lane[access_addr];
        end
      end
      assign DATA_LANE_OUT[g*SBSP_BYTE_W +: SBSP_BYTE_W] = rd_reg[SBSP_BYTE_W-1:0];
      assign PARITY_LANE_OUT[g] = rd_reg[SBSP_BYTE_W];
    end
  endgenerate

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_sleep_hiz: assert property (SLEEP_REQUEST |-> !DATA_LANE_OE && POWER_DOWN)
    else $error("outputs driven during sleep");
  a_oe_gate: assert property (OUTPUT_ENABLE_N |-> !DATA_LANE_OE)
    else $error("outputs driven with output enable high");
  a_deselect_pd: assert property (!SLEEP_REQUEST && deselect |=> pd_reg && !drive_reg)
    else $error("deselect did not power down");
  a_processor_addr_strobe_n_read: assert property (op == SBSP_OP_START_READ |=> drive_reg && burst_reg.count == SBSP_COUNT_ZERO)
    else $error("processor strobe did not start read");
  a_ctl_write: assert property (op == SBSP_OP_START_CTL && wr_any |=> !drive_reg && active_reg)
    else $error("controller strobe write wrong");
  a_global_write: assert property (!ALL_BYTES_WRITE_N && do_write |-> &lane_we)
    else $error("global write missed a lane");
  a_step_count: assert property (op == SBSP_OP_STEP |=> burst_reg.count == $past(burst_reg.count) + SBSP_COUNT_STEP)
    else $error("burst did not step");
  a_hold_count: assert property (op == SBSP_OP_HOLD |=> $stable(burst_reg) && $stable(addr_hi_reg))
    else $error("suspend changed address");
  a_order_ilv: assert property (BURST_ORDER_SEL && op == SBSP_OP_STEP && burst_reg.count == SBSP_COUNT_ZERO
                                |-> low_addr == (burst_reg.start ^ SBSP_COUNT_STEP))
    else $error("interleaved order wrong");
  a_wrap_start: assert property (op == SBSP_OP_STEP [*4] |-> burst_next.count == $past(burst_reg.count, 3))
    else $error("burst did not wrap");
  a_reset_hiz: assert property (disable iff (1'b0) RESET |=> !DATA_LANE_OE)
    else $error("outputs driven after reset");

  c_read_burst: cover property (op == SBSP_OP_START_READ ##1 op == SBSP_OP_STEP [*3]);
  c_write_burst: cover property (op == SBSP_OP_START_CTL && wr_any ##1 op == SBSP_OP_HOLD ##1 op == SBSP_OP_STEP);
  c_snooze: cover property (active_reg ##1 SLEEP_REQUEST);
endmodule : sbsp_port
`default_nettype wire

// ### shared/sbsp_pkg.sv
// sbsp_pkg: shared types and constants of the synchronous burst sram port
// assumes: one clock, no register bus, inputs synchronous to the clock except output enable and sleep
`default_nettype none
package sbsp_pkg;
  localparam int   SBSP_BURST_W  = 2;
  localparam int   SBSP_BYTE_W   = 8;
  localparam int   SBSP_WORD_W   = SBSP_BYTE_W + 1;
  localparam int   SBSP_LANES    = 4;
  localparam int   SBSP_ADDR_W   = 20;
  localparam logic [SBSP_BURST_W-1:0] SBSP_COUNT_ZERO = 2'h0;
  localparam logic [SBSP_BURST_W-1:0] SBSP_COUNT_STEP = 2'h1;

  // --------------------------------------------------------------
  // cycle kinds decoded at a rising edge
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    SBSP_OP_IDLE,
    SBSP_OP_SNOOZE,
    SBSP_OP_DESELECT,
    SBSP_OP_START_READ,
    SBSP_OP_START_CTL,
    SBSP_OP_STEP,
    SBSP_OP_HOLD
  } sbsp_op_t;

  typedef struct packed {
    logic [SBSP_BURST_W-1:0] start;
    logic [SBSP_BURST_W-1:0] count;
  } sbsp_burst_t;
endpackage : sbsp_pkg
`default_nettype wire

// ### test/sbsp_master.sv
// sbsp_master: bus master model that drives the sram port pins
// assumes: op is called just after a falling clock edge
`default_nettype none
module sbsp_master
  import sbsp_pkg::*;
(
  output var logic [5:0]  ADDR_HI,
  output var logic [1:0]  ADDR_LO,
  output var logic [3:0]  CTL_N,
  output var logic [5:0]  WR_N,
  output var logic        OE_N,
  output var logic [35:0] WORD
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {ADDR_HI, ADDR_LO} = 8'h00;
    CTL_N = 4'hf;
    WR_N = 6'h3f;
    OE_N = 1'b1;
    WORD = 36'h0;
  end
  // c = cs, processor strobe, controller strobe, advance; w = all, gate, lanes
  task automatic op(input logic [3:0] c, input logic [5:0] w, input logic [7:0] a, input logic [35:0] d);
    logic wr;
    wr = !w[5] || (!w[4] && !(&w[3:0]));
    CTL_N = c;
    WR_N = w;
    {ADDR_HI, ADDR_LO} = a;
    OE_N = wr && c[2];
    WORD = wr ? d : ~WORD;
  endtask : op
endmodule : sbsp_master
`default_nettype wire

// ### test/test_sync_burst_sram_port.sv
// test_sync_burst_sram_port: self-checking bench of the burst sram port
// assumes: sbsp_pkg and sbsp_master compiled first
`default_nettype none
module test_sync_burst_sram_port
  import sbsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset = 1'b1, sleep = 1'b0, order = 1'b1, ce_hi = 1'b1, ce2_n = 1'b0;
  logic [5:0]  a_hi, wr_n;
  logic [1:0]  a_lo;
  logic [3:0]  ctl_n, p_out;
  logic [31:0] d_out;
  logic [35:0] word;
  logic        oe_n, oe, p_oe, pd;
  int          bad_count = 0, checked = 0, cycles = 0;
  initial forever #5 clk = ~clk;
  sbsp_master sbsp_master_i (.ADDR_HI(a_hi), .ADDR_LO(a_lo), .CTL_N(ctl_n), .WR_N(wr_n), .OE_N(oe_n), .WORD(word));
  sbsp_port #(.ADDR_W(8), .LANES(4)) sbsp_port_i (
    .CLK(clk), .RESET(reset), .ADDRESS_HI(a_hi), .BURST_LSB_ADDRESS(a_lo),
    .CHIP_SELECT_N(ctl_n[3]), .CHIP_SELECT_HI(ce_hi), .CHIP_SELECT2_N(ce2_n),
    .PROCESSOR_ADDR_STROBE_N(ctl_n[2]), .CONTROLLER_ADDR_STROBE_N(ctl_n[1]), .BURST_ADVANCE_N(ctl_n[0]),
    .ALL_BYTES_WRITE_N(wr_n[5]), .BYTE_WRITE_GATE_N(wr_n[4]), .BYTE_LANE_WRITE_N(wr_n[3:0]),
    .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep), .BURST_ORDER_SEL(order),
    .DATA_LANE_IN(word[31:0]), .DATA_LANE_OUT(d_out), .DATA_LANE_OE(oe),
    .PARITY_LANE_IN(word[35:32]), .PARITY_LANE_OUT(p_out), .PARITY_LANE_OE(p_oe), .POWER_DOWN(pd));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [36:0] s, input logic [36:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input logic [3:0] c, input logic [5:0] w, input logic [7:0] a, input logic [35:0] d);
    sbsp_master_i.op(c, w, a, d);
    @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic rd(input logic [3:0] c, input logic [5:0] w, input logic [7:0] a, input logic [35:0] e);
    cyc(c, w, a, ~e);
    chk("rdata", {oe, p_out, d_out}, {1'b1, e});
    chk("parity_oe", 37'(p_oe), 37'h1);
  endtask : rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_rw();
    cyc(4'h5, 6'h1f, 8'h11, 36'h8_1234_5678);
    cyc(4'h6, 6'h1f, 8'h00, 36'h3_0bad_cafe);
    cyc(4'h7, 6'h1f, 8'h00, 36'h6_5555_aaaa);
    chk("oe_write", 37'(oe), 37'h0);
    rd(4'h3, 6'h1f, 8'h11, 36'h8_1234_5678);
    rd(4'h6, 6'h3f, 8'h00, 36'h6_5555_aaaa);
    rd(4'h3, 6'h3f, 8'h11, 36'h8_1234_5678);
    cyc(4'h5, 6'h2e, 8'h11, 36'hf_ffff_ffff);
    rd(4'h5, 6'h2f, 8'h11, 36'h9_1234_56ff);
    rd(4'h3, 6'h3f, 8'h10, 36'h6_5555_aaaa);
    cyc(4'h7, 6'h1f, 8'h00, 36'h5_0f0f_f0f0);
    chk("oe_wr_after_rd", 37'(oe), 37'h0);
    rd(4'h3, 6'h3f, 8'h10, 36'h5_0f0f_f0f0);
    $display("done read and write bursts");
  endtask : t_rw
  task automatic t_desel();
    cyc(4'hd, 6'h3f, 8'h11, 36'h0);
    chk("desel", {oe, 35'h0, pd}, 37'h1);
    cyc(4'h6, 6'h3f, 8'h11, 36'h0);
    chk("idle_oe", 37'(oe), 37'h0);
    ce_hi = 1'b0;
    cyc(4'h3, 6'h3f, 8'h11, 36'h0);
    chk("desel_hi", {oe, 35'h0, pd}, 37'h1);
    ce_hi = 1'b1;
    ce2_n = 1'b1;
    cyc(4'h5, 6'h3f, 8'h11, 36'h0);
    chk("desel_2n", {oe, 35'h0, pd}, 37'h1);
    ce2_n = 1'b0;
    rd(4'h3, 6'h3f, 8'h11, 36'h9_1234_56ff);
    sleep = 1'b1;
    #1;
    chk("sleep", {oe, 35'h0, pd}, 37'h1);
    cyc(4'h3, 6'h3f, 8'h11, 36'h0);
    chk("sleep_edge", {oe, 35'h0, pd}, 37'h1);
    sleep = 1'b0;
    $display("done deselect and sleep");
  endtask : t_desel
  task automatic t_order();
    logic [1:0] lo;
    for (int k = 0; k < 4; k++) cyc(k ? 4'h6 : 4'h5, 6'h1f, 8'h20, {30'h1400_0002, 2'(k)});
    for (int m = 0; m < 2; m++) begin
      order = m[0];
      for (int k = 0; k < 5; k++) begin
        lo = m ? 2'(3 ^ k) : 2'(3 + k);
        rd(k ? 4'h6 : 4'h3, 6'h3f, 8'h23, {30'h1400_0002, lo});
      end
    end
    $display("done burst orders");
  endtask : t_order
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    chk("reset", {oe, 35'h0, pd}, 37'h1);
    t_rw();
    t_desel();
    t_order();
    conclude();
  end
endmodule : test_sync_burst_sram_port
`default_nettype wire
